// ==== sms_defines.svh ====
// timing counts, field positions and reset values for the short-message send sequencer
// assumes a 40 MHz clock and one scan tick input per program scan
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH
`define SMS_CLK_MHZ        40
`define SMS_RETRY_MAX      3
`define SMS_RETRY_WIN_S    120
`define SMS_RETRY_WIN_CYC  (`SMS_RETRY_WIN_S * `SMS_CLK_MHZ * 64'd1000000)
// gap is a quarter of the window so three gaps plus the attempts fit inside it;
// worked in seconds first so the product stays inside a 32-bit int
`define SMS_RETRY_GAP_CYC  ((`SMS_RETRY_WIN_S / (`SMS_RETRY_MAX + 1)) * `SMS_CLK_MHZ * 1000000)
`define SMS_ST_DONE        0
`define SMS_ST_BUSY        1
`define SMS_ST_WAIT        2
`define SMS_ST_FAIL        3
`define SMS_ST_PERR        4
`define SMS_STATUS_RST     16'h0000
`define SMS_NUM_UNITS      4
`endif

// ==== sms_pkg.sv ====
// types used by the sequencer; the arbiter does not use them
package sms_pkg;
  typedef enum logic [2:0] {
    SMS_IDLE  = 3'b000,
    SMS_WAIT  = 3'b001,
    SMS_SEND  = 3'b010,
    SMS_GAP   = 3'b011,
    SMS_DONE  = 3'b100,
    SMS_HOLD  = 3'b101
  } sms_state_e;
endpackage

// ==== sms_fifo_arb.sv ====
// first-in first-out arbiter for the shared modem
// assumes each requester raises req once and holds it until released
`timescale 1ns/1ps
`include "sms_defines.svh"
module sms_fifo_arb #(
  parameter int N = `SMS_NUM_UNITS
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] release_req,
  output logic      [N-1:0] grant
);
  localparam int IW = (N > 1) ? $clog2(N) : 1;
  logic [IW-1:0] q_ff [N];
  logic [IW:0]   cnt_ff, nxt_cnt;
  logic [IW-1:0] nxt_q [N];
  logic [N-1:0]  queued_ff, nxt_queued;

  // ******************************
  // queue update
  // ******************************
  always_comb
  begin
    logic [IW:0] c;
    c = cnt_ff;
    nxt_queued = queued_ff;
    for (int i = 0; i < N; i++)
      nxt_q[i] = q_ff[i];
    // pop the head when the holder releases
    if (c != '0 && release_req[q_ff[0]])
    begin
      for (int i = 0; i < N - 1; i++)
        nxt_q[i] = q_ff[i + 1];
      nxt_queued[q_ff[0]] = 1'b0;
      c = c - 1'b1;
    end
    // lowest index wins a tie within one cycle
    for (int i = 0; i < N; i++)
      if (req[i] && !queued_ff[i] && !release_req[i])
      begin
        nxt_q[c[IW-1:0]] = IW'(i);
        nxt_queued[i] = 1'b1;
        c = c + 1'b1;
      end
    nxt_cnt = c;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_ff    <= '0;
      queued_ff <= '0;
      for (int i = 0; i < N; i++)
        q_ff[i] <= '0;
    end
    else
    begin
      cnt_ff    <= nxt_cnt;
      queued_ff <= nxt_queued;
      for (int i = 0; i < N; i++)
        q_ff[i] <= nxt_q[i];
    end
  end

  always_comb
  begin
    grant = '0;
    if (cnt_ff != '0)
      grant[q_ff[0]] = 1'b1;
  end
endmodule // sms_fifo_arb

// ==== sms_send_seq.sv ====
// send sequencers for several short-message units sharing one modem
// assumes scan_tick pulses once per program scan; modem handshake is on the same clock
`timescale 1ns/1ps
`include "sms_defines.svh"
module sms_send_seq #(
  parameter int N             = `SMS_NUM_UNITS,
  parameter int RETRY_GAP_CYC = `SMS_RETRY_GAP_CYC
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          scan_tick,
  input  wire logic [N-1:0]  bit_in,
  input  wire logic [N-1:0]  dest_is_email,
  input  wire logic [N-1:0]  param_ok,
  input  wire logic          remote_access,
  input  wire logic          modem_ready,
  input  wire logic          send_done,
  input  wire logic          send_ok,
  input  wire logic [15:0]   mobile_centre_number,
  input  wire logic [15:0]   gateway_centre_number,
  output logic               send_start,
  output logic [1:0]         send_unit,
  output logic [15:0]        send_centre,
  output logic [N-1:0]       bit_out,
  output logic [N*16-1:0]    status_word
);
  localparam int CW = $clog2(RETRY_GAP_CYC + 1);
  logic [N-1:0]          grant;
  logic [N-1:0]          req;
  logic [N-1:0]          rel;
  sms_pkg::sms_state_e   st_ff    [N];
  sms_pkg::sms_state_e   nxt_st   [N];
  logic [1:0]            try_ff   [N];
  logic [1:0]            nxt_try  [N];
  logic [CW-1:0]         gap_ff   [N];
  logic [CW-1:0]         nxt_gap  [N];
  logic [4:0]            stat_ff  [N];
  logic [4:0]            nxt_stat [N];
  logic [N-1:0]          dropped_ff, nxt_dropped;
  logic [N-1:0]          out_ff, nxt_out;
  logic                  start_ff, nxt_start;
  logic [1:0]            unit_ff, nxt_unit;
  logic [15:0]           ctr_ff, nxt_ctr;

  sms_fifo_arb #(.N(N)) u_arb (
    .clk         (clk),
    .reset       (reset),
    .req         (req),
    .release_req (rel),
    .grant       (grant)
  );

  // ******************************
  // per-unit sequencing
  // ******************************
  always_comb
  begin
    nxt_start   = 1'b0;
    nxt_unit    = unit_ff;
    nxt_ctr     = ctr_ff;
    nxt_dropped = dropped_ff;
    nxt_out     = out_ff;
    req = '0;
    rel = '0;
    for (int i = 0; i < N; i++)
    begin
      nxt_st[i]   = st_ff[i];
      nxt_try[i]  = try_ff[i];
      nxt_gap[i]  = gap_ff[i];
      nxt_stat[i] = stat_ff[i];
      req[i] = (st_ff[i] == sms_pkg::SMS_WAIT);
      if (st_ff[i] != sms_pkg::SMS_IDLE && !bit_in[i])
        nxt_dropped[i] = 1'b1;
      case (st_ff[i])
        sms_pkg::SMS_IDLE:
          // modem is only armed when remote access is off
          if (bit_in[i] && scan_tick && !remote_access)
          begin
            if (!param_ok[i])
            begin
              nxt_stat[i] = 5'h10;
              nxt_out[i]  = 1'b1;
              nxt_st[i]   = sms_pkg::SMS_DONE;
            end
            else
            begin
              nxt_st[i]   = sms_pkg::SMS_WAIT;
              nxt_stat[i] = 5'h04;
              nxt_try[i]  = 2'h0;
            end
          end
        sms_pkg::SMS_WAIT:
          if (grant[i] && modem_ready && !remote_access && !start_ff)
          begin
            nxt_st[i]   = sms_pkg::SMS_SEND;
            nxt_stat[i] = 5'h02;
            nxt_start   = 1'b1;
            nxt_unit    = 2'(i);
            nxt_ctr     = dest_is_email[i] ? gateway_centre_number : mobile_centre_number;
          end
        sms_pkg::SMS_SEND:
          if (send_done)
          begin
            if (send_ok)
            begin
              nxt_stat[i] = 5'h01;
              nxt_out[i]  = 1'b1;
              nxt_st[i]   = sms_pkg::SMS_DONE;
              rel[i]      = 1'b1;
            end
            else if (try_ff[i] == 2'(`SMS_RETRY_MAX))
            begin
              nxt_stat[i] = 5'h09;
              nxt_out[i]  = 1'b1;
              nxt_st[i]   = sms_pkg::SMS_DONE;
              rel[i]      = 1'b1;
            end
            else
            begin
              nxt_try[i] = try_ff[i] + 2'h1;
              nxt_gap[i] = CW'(RETRY_GAP_CYC);
              nxt_st[i]  = sms_pkg::SMS_GAP;
            end
          end
        sms_pkg::SMS_GAP:
          if (gap_ff[i] != '0)
            nxt_gap[i] = gap_ff[i] - 1'b1;
          else if (!remote_access)
          begin
            nxt_st[i]  = sms_pkg::SMS_SEND;
            nxt_start  = 1'b1;
          end
        sms_pkg::SMS_DONE:
          if (scan_tick)
            nxt_st[i] = sms_pkg::SMS_HOLD;
        sms_pkg::SMS_HOLD:
          // one scan of output after completion, then off unless input still held and never dropped since leaving idle
          if (scan_tick && (!bit_in[i] || dropped_ff[i]))
          begin
            nxt_out[i]     = 1'b0;
            nxt_stat[i]    = 5'h00;
            nxt_dropped[i] = 1'b0;
            nxt_st[i]      = sms_pkg::SMS_IDLE;
          end
        default:
          nxt_st[i] = sms_pkg::SMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      start_ff   <= 1'b0;
      unit_ff    <= 2'h0;
      ctr_ff     <= 16'h0000;
      dropped_ff <= '0;
      out_ff     <= '0;
      for (int i = 0; i < N; i++)
      begin
        st_ff[i]   <= sms_pkg::SMS_IDLE;
        try_ff[i]  <= 2'h0;
        gap_ff[i]  <= '0;
        stat_ff[i] <= 5'h00;
      end
    end
    else
    begin
      start_ff   <= nxt_start;
      unit_ff    <= nxt_unit;
      ctr_ff     <= nxt_ctr;
      dropped_ff <= nxt_dropped;
      out_ff     <= nxt_out;
      for (int i = 0; i < N; i++)
      begin
        st_ff[i]   <= nxt_st[i];
        try_ff[i]  <= nxt_try[i];
        gap_ff[i]  <= nxt_gap[i];
        stat_ff[i] <= nxt_stat[i];
      end
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign send_start  = start_ff;
  assign send_unit   = unit_ff;
  assign send_centre = ctr_ff;
  assign bit_out     = out_ff;
  always_comb
  begin
    for (int i = 0; i < N; i++)
      status_word[i*16 +: 16] = {11'h000, stat_ff[i]};
  end

  // ******************************
  // checks
  // ******************************
  chk_one_grant_only: assert property (@(posedge clk) disable iff (reset) $onehot0(grant))
    else $error("more than one unit granted");
  chk_no_start_remote: assert property (@(posedge clk) disable iff (reset)
    $rose(start_ff) |-> !$past(remote_access))
    else $error("send started under remote access");
  chk_out_clears_stat: assert property (@(posedge clk) disable iff (reset)
    $fell(out_ff[0]) |-> stat_ff[0] == 5'h00)
    else $error("status not cleared with output");
  chk_fail_after_three: assert property (@(posedge clk) disable iff (reset)
    $rose(stat_ff[0][`SMS_ST_FAIL]) |-> $past(try_ff[0]) == 2'h3 && out_ff[0])
    else $error("failure reported before third retry");
  chk_done_sets_out: assert property (@(posedge clk) disable iff (reset)
    $rose(stat_ff[0][`SMS_ST_DONE]) |-> out_ff[0])
    else $error("success without output");
  chk_send_continues: assert property (@(posedge clk) disable iff (reset)
    st_ff[0] == sms_pkg::SMS_SEND && !send_done |=> st_ff[0] == sms_pkg::SMS_SEND)
    else $error("send abandoned");
  chk_wait_ignores_in: assert property (@(posedge clk) disable iff (reset)
    st_ff[0] == sms_pkg::SMS_WAIT && !grant[0] |=> st_ff[0] == sms_pkg::SMS_WAIT)
    else $error("waiting unit moved without grant");
  chk_retry_bounded: assert property (@(posedge clk) disable iff (reset)
    st_ff[0] == sms_pkg::SMS_GAP |-> try_ff[0] != 2'h0)
    else $error("retry gap with no retry counted");
  chk_centre_route: assert property (@(posedge clk) disable iff (reset)
    $rose(start_ff) && st_ff[0] == sms_pkg::SMS_SEND && unit_ff == 2'h0 |->
    ctr_ff == ($past(dest_is_email[0]) ? $past(gateway_centre_number) : $past(mobile_centre_number)))
    else $error("wrong centre number");
  cov_success: cover property (@(posedge clk) $rose(stat_ff[0][`SMS_ST_DONE]));
  cov_fail: cover property (@(posedge clk) $rose(stat_ff[0][`SMS_ST_FAIL]));
  cov_two_wait: cover property (@(posedge clk) st_ff[0] == sms_pkg::SMS_SEND && st_ff[1] == sms_pkg::SMS_WAIT);
endmodule // sms_send_seq

// ==== sms_modem_model.sv ====
// behavioural model of the shared modem facing the send sequencer
// assumes one attempt at a time, started by a one-cycle send_start
`timescale 1ns/1ps
module sms_modem_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       send_start,
  input  wire logic [1:0] send_unit,
  input  wire logic [3:0] fail_mask,
  input  wire logic [3:0] delay,
  output logic            modem_ready,
  output logic            send_done,
  output logic            send_ok
);
  logic [3:0] cnt_ff;
  logic       busy_ff;
  logic       ok_ff;
  logic       tog_ff;
  // ********************
  // attempt timing
  // ********************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      {cnt_ff, busy_ff, ok_ff, tog_ff, modem_ready, send_done} <= '0;
    end
    else
    begin
      tog_ff      <= ~tog_ff;
      modem_ready <= 1'b1;
      send_done   <= 1'b0;
      if (send_start)
      begin
        busy_ff <= 1'b1;
        cnt_ff  <= delay;
        ok_ff   <= ~fail_mask[send_unit];
      end
      else if (busy_ff && cnt_ff == 4'h0)
      begin
        busy_ff   <= 1'b0;
        send_done <= 1'b1;
      end
      else if (busy_ff)
      begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  // outcome is only meaningful with send_done; toggles otherwise so no stale value is trusted
  assign send_ok = send_done ? ok_ff : tog_ff;
endmodule // sms_modem_model

// ==== tb_top.sv ====
// self-checking bench for the short-message send sequencer
// assumes the modem model above and a scan tick every eight clocks
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        reset;
  logic        scan_tick;
  logic [3:0]  bit_in;
  logic [3:0]  dest_is_email;
  logic [3:0]  param_ok;
  logic        remote_access;
  logic [3:0]  fail_mask;
  logic [3:0]  delay;
  logic [15:0] mobile;
  logic [15:0] gateway;
  logic        modem_ready;
  logic        send_done;
  logic        send_ok;
  logic        send_start;
  logic [1:0]  send_unit;
  logic [15:0] send_centre;
  logic [3:0]  bit_out;
  logic [63:0] status_word;
  logic [31:0] rng;
  int          fail_count;
  int          n_compared;
  int          starts[4];
  int          order[$];
  int          sc;
  int          u;
  int          n;
  // ********************
  // instances
  // ********************
  sms_modem_model modem (.clk(clk), .reset(reset), .send_start(send_start), .send_unit(send_unit),
    .fail_mask(fail_mask), .delay(delay), .modem_ready(modem_ready), .send_done(send_done), .send_ok(send_ok));
  sms_send_seq #(.N(4), .RETRY_GAP_CYC(20)) dut (.clk(clk), .reset(reset), .scan_tick(scan_tick),
    .bit_in(bit_in), .dest_is_email(dest_is_email), .param_ok(param_ok), .remote_access(remote_access),
    .modem_ready(modem_ready), .send_done(send_done), .send_ok(send_ok), .mobile_centre_number(mobile),
    .gateway_centre_number(gateway), .send_start(send_start), .send_unit(send_unit),
    .send_centre(send_centre), .bit_out(bit_out), .status_word(status_word));
  // ********************
  // helpers
  // ********************
  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // centre number a unit's destination should be routed through
  function logic [15:0] exp_centre(input logic [1:0] i);
    return dest_is_email[i] ? gateway : mobile;
  endfunction
  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait on one status bit of one unit
  task wait_until(input int i, input int b, input logic v);
    int k;
    for (k = 0; k < 4000 && status_word[16*i+b] !== v; k++)
      @(posedge clk) #1;
    if (status_word[16*i+b] !== v)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  // waits on the output itself: a parameter error never sets the complete bit
  task clear_unit(input int i);
    int k;
    bit_in[i] = 1'b0;
    for (k = 0; k < 4000 && bit_out[i] !== 1'b0; k++)
      @(posedge clk) #1;
    if (bit_out[i] !== 1'b0)
    begin
      fail_count++;
      stop_test();
    end
    check({15'h0, bit_out[i]}, 16'h0000);
    check(status_word[16*i +: 16], 16'h0000);
  endtask
  // ********************
  // clock, scan tick, monitor
  // ********************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    #1 scan_tick = (sc % 8 == 7);
    sc++;
    if (send_start === 1'b1)
      delay = 4'h8 | 4'(rnd());
  end
  always @(negedge clk)
    if (send_start === 1'b1)
    begin
      starts[send_unit]++;
      order.push_back(send_unit);
      check(send_centre, exp_centre(send_unit));
    end
  // ********************
  // main sequence
  // ********************
  initial
  begin
    rng = 32'h9ee53e23;
    {reset, scan_tick, sc} = {1'b1, 1'b0, 32'd0};
    {bit_in, dest_is_email, param_ok, remote_access, fail_mask, delay} = {4'h0, 4'h8, 4'hf, 1'b0, 4'h0, 4'h9};
    mobile = 16'(rnd());
    gateway = 16'(rnd());
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    // two units asking together: lowest first, other waits its turn
    bit_in = 4'b1001;
    wait_until(0, 0, 1'b1);
    check(status_word[48 +: 16], 16'h0004);
    wait_until(3, 0, 1'b1);
    check(order[0][15:0], 16'h0000);
    check(order[1][15:0], 16'h0003);
    check(status_word[15:0], 16'h0001);
    check(status_word[48 +: 16], 16'h0001);
    repeat (24) @(posedge clk) #1;
    check({15'h0, bit_out[0]}, 16'h0001);
    clear_unit(0);
    clear_unit(3);
    // input dropped while waiting, raised again mid-send
    bit_in[1] = 1'b1;
    wait_until(1, 2, 1'b1);
    bit_in[1] = 1'b0;
    wait_until(1, 1, 1'b1);
    bit_in[1] = 1'b1;
    wait_until(1, 0, 1'b1);
    bit_in[1] = 1'b0;
    check(status_word[31:16], 16'h0001);
    check(starts[1][15:0], 16'h0001);
    // input gone after completion: output stands one scan past the next tick, then drops
    for (n = 0; n < 40 && bit_out[1] === 1'b1; n++)
      @(posedge clk) #1;
    check({15'h0, n >= 9 && n <= 16}, 16'h0001);
    clear_unit(1);
    // every attempt fails: three retries then failure code
    fail_mask = 4'b0100;
    bit_in[2] = 1'b1;
    wait_until(2, 1, 1'b1);
    bit_in[2] = 1'b0;
    repeat (3) @(posedge clk) #1;
    bit_in[2] = 1'b1;
    wait_until(2, 0, 1'b1);
    check(starts[2][15:0], 16'h0004);
    check(status_word[47:32], 16'h0009);
    check({15'h0, bit_out[2]}, 16'h0001);
    clear_unit(2);
    fail_mask = 4'h0;
    // remote access blocks sending
    remote_access = 1'b1;
    bit_in[0] = 1'b1;
    repeat (40) @(posedge clk) #1;
    check(status_word[15:0], 16'h0000);
    check(starts[0][15:0], 16'h0001);
    {bit_in[0], remote_access} = 2'b00;
    repeat (16) @(posedge clk) #1;
    // bad parameters end without modem use
    param_ok[3] = 1'b0;
    bit_in[3] = 1'b1;
    wait_until(3, 4, 1'b1);
    check(status_word[63:48], 16'h0010);
    check(starts[3][15:0], 16'h0001);
    clear_unit(3);
    param_ok = 4'hf;
    // random units and destinations
    repeat (6)
    begin
      u = rnd() % 4;
      dest_is_email = 4'(rnd());
      bit_in[u] = 1'b1;
      wait_until(u, 0, 1'b1);
      check(status_word[16*u +: 16], 16'h0001);
      clear_unit(u);
    end
    stop_test();
  end
endmodule // tb_top
